/* src/slsu_pkg.sv */
// package of constants for the scalar logic and shift unit
// assumes a 100 MHz system clock and two phases per clock period
// Functional notes
// - logical product opcode ANDs both operands bitwise into destination.
// - AND-NOT opcode inverts second operand, ANDs with first operand.
// - logical difference opcode writes bitwise XOR of both operands.
// - logical sum opcode writes bitwise OR of both operands.
// - integer sum opcode adds both operands, 64-bit wrapping result.
// - integer difference subtracts second operand from first operand.
// - population count delivers seven-bit count of one bits.
// - k designator bit zero set keeps only count parity bit.
// - leading-zero count returns zeros before first one, 0 to 64.
// - immediate left shift of destination by six parcel bits, zero fill.
// - immediate right shift of destination by six parcel bits, zero fill.
// - double left shift joins destination above first operand, zero fill.
// - double shift returns window at destination's original position.
// - double shift count is address register as 32-bit unsigned.
// - count of 128 or more gives zero, 64 first operand, 0 destination.
// - issue needs sources free phase 5; next issue in phase 2; unit here refuses issue while o_busy.
// - bitwise ops: path free phase 6, destination free phase 7.
// - add, subtract, shifts: path free phase 14, destination phase 15.
// - counts: path free phase 20, destination free phase 21.
// - timing counts two phases per clock period.
package slsu_pkg;
    localparam int SLSU_DW = 64;
    localparam int SLSU_CW = 32;
    // opcode field values, three octal digits
    localparam logic [8:0] SLSU_OP_AND = 9'h040;
    localparam logic [8:0] SLSU_OP_ANDN = 9'h041;
    localparam logic [8:0] SLSU_OP_XOR = 9'h042;
    localparam logic [8:0] SLSU_OP_OR = 9'h043;
    localparam logic [8:0] SLSU_OP_ADD = 9'h044;
    localparam logic [8:0] SLSU_OP_SUB = 9'h045;
    localparam logic [8:0] SLSU_OP_POP = 9'h046;
    localparam logic [8:0] SLSU_OP_LZC = 9'h047;
    localparam logic [8:0] SLSU_OP_SHL = 9'h048;
    localparam logic [8:0] SLSU_OP_SHR = 9'h049;
    localparam logic [8:0] SLSU_OP_DSHL = 9'h04A;
    // phase timing
    localparam int SLSU_PHASES_PER_CLK = 2;
    localparam int SLSU_PH_ISSUE_NEXT = 2;
    localparam int SLSU_PH_SRC_FREE = 5;
    localparam int SLSU_PH_LOG_PATH = 6;
    localparam int SLSU_PH_LOG_FREE = 7;
    localparam int SLSU_PH_ARI_PATH = 14;
    localparam int SLSU_PH_ARI_FREE = 15;
    localparam int SLSU_PH_CNT_PATH = 20;
    localparam int SLSU_PH_CNT_FREE = 21;
    // phase figures to clock cycles, rounded up
    localparam int SLSU_CYC_LOG =
        (SLSU_PH_LOG_FREE + SLSU_PHASES_PER_CLK - 1) / SLSU_PHASES_PER_CLK;
    localparam int SLSU_CYC_ARI =
        (SLSU_PH_ARI_FREE + SLSU_PHASES_PER_CLK - 1) / SLSU_PHASES_PER_CLK;
    localparam int SLSU_CYC_CNT =
        (SLSU_PH_CNT_FREE + SLSU_PHASES_PER_CLK - 1) / SLSU_PHASES_PER_CLK;
    localparam logic [SLSU_CW-1:0] SLSU_DSH_FULL = 32'h00000080;
    localparam logic [SLSU_CW-1:0] SLSU_DSH_HALF = 32'h00000040;
    localparam logic [SLSU_DW-1:0] SLSU_ZERO = 64'h0000000000000000;
    typedef enum logic [2:0] {
        SLSU_ST_IDLE = 3'b001,
        SLSU_ST_BUSY = 3'b010,
        SLSU_ST_DONE = 3'b100
    } slsu_state_t;
endpackage : slsu_pkg

/* src/slsu_cnt_if.sv */
// interface carrying the count unit operand and results
// assumes a single system clock domain
`timescale 1ns/100ps
interface slsu_cnt_if;
    logic [63:0] operand;
    logic [6:0] ones;
    logic [6:0] lead_zeros;
    modport unit (input operand, output ones, output lead_zeros);
    modport user (output operand, input ones, input lead_zeros);
endinterface : slsu_cnt_if

/* src/slsu_count.sv */
// population and leading-zero counter for one 64-bit word
// assumes purely combinational use by the datapath
`timescale 1ns/100ps
module slsu_count
(
    slsu_cnt_if.unit cnt
);
    logic [6:0] pop_acc [0:64];
    logic [64:0] seen;
    logic [6:0] lz_acc [0:64];
    assign pop_acc[0] = 7'h00;
    assign lz_acc[0] = 7'h00;
    assign seen[0] = 1'b0;
    // walk bits from the top: ones tally and zeros before the first one
    genvar g;
    generate
        for (g = 0; g < 64; g++)
        begin : g_bit
            assign pop_acc[g+1] = pop_acc[g]
                + {6'h00, cnt.operand[63-g]};
            assign seen[g+1] = seen[g] | cnt.operand[63-g];
            assign lz_acc[g+1] = lz_acc[g] + {6'h00, ~seen[g+1]};
        end
    endgenerate
    assign cnt.ones = pop_acc[64];
    assign cnt.lead_zeros = lz_acc[64];
endmodule : slsu_count

/* src/slsu_unit.sv */
// scalar logic and shift unit datapath with phase-timed completion
// assumes issue control checks source availability before i_issue
`timescale 1ns/100ps
module slsu_unit
    import slsu_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_issue,
    input wire logic [8:0] i_opcode,
    input wire logic [2:0] i_k_designator,
    input wire logic [5:0] i_parcel_shift_constant,
    input wire logic [63:0] i_first_scalar_operand,
    input wire logic [63:0] i_second_scalar_operand,
    input wire logic [63:0] i_dest_operand,
    input wire logic [31:0] i_shift_count_addr_reg,
    output logic o_issue_ready,
    output logic o_busy,
    output logic o_result_valid,
    output logic [63:0] o_result
);
    slsu_state_t state_r;
    slsu_state_t state_nxt;
    logic [63:0] result_r;
    logic [63:0] hold_r;
    logic [3:0] wait_r;
    logic [3:0] wait_nxt;
    logic legal_op;
    logic [3:0] lat_cyc;
    logic [63:0] sel_result;
    slsu_cnt_if cnt_bus ();
    // count unit on the first operand
    assign cnt_bus.operand = i_first_scalar_operand;
    slsu_count u_count (.cnt(cnt_bus.unit));
    // bitwise results
    wire [63:0] r_and = i_first_scalar_operand
        & i_second_scalar_operand;
    wire [63:0] r_andn = i_first_scalar_operand
        & ~i_second_scalar_operand;
    wire [63:0] r_xor = i_first_scalar_operand
        ^ i_second_scalar_operand;
    wire [63:0] r_or = i_first_scalar_operand
        | i_second_scalar_operand;
    // integer results, 64-bit wraparound
    wire [63:0] r_add = i_first_scalar_operand
        + i_second_scalar_operand;
    wire [63:0] r_sub = i_first_scalar_operand
        - i_second_scalar_operand;
    // counts, zero-extended; parity keeps bit zero only
    wire [6:0] pop_sel = i_k_designator[0]
        ? {6'h00, cnt_bus.ones[0]} : cnt_bus.ones;
    wire [63:0] r_pop = {57'h0, pop_sel};
    wire [63:0] r_lzc = {57'h0, cnt_bus.lead_zeros};
    // immediate shifts of the destination, zero fill
    wire [63:0] r_shl = i_dest_operand << i_parcel_shift_constant;
    wire [63:0] r_shr = i_dest_operand >> i_parcel_shift_constant;
    // double shift: destination high, first operand low, upper window out
    wire [127:0] dsh_field = {i_dest_operand, i_first_scalar_operand};
    wire dsh_zero = i_shift_count_addr_reg >= SLSU_DSH_FULL;
    wire [127:0] dsh_shifted = dsh_field << i_shift_count_addr_reg[6:0];
    wire [63:0] r_dshl = dsh_zero ? SLSU_ZERO : dsh_shifted[127:64];
    // opcode selection and latency class in clock cycles
    always_comb
    begin
        legal_op = 1'b1;
        lat_cyc = 4'(SLSU_CYC_ARI);
        sel_result = SLSU_ZERO;
        unique case (i_opcode)
            SLSU_OP_AND:
            begin
                sel_result = r_and;
                lat_cyc = 4'(SLSU_CYC_LOG);
            end
            SLSU_OP_ANDN:
            begin
                sel_result = r_andn;
                lat_cyc = 4'(SLSU_CYC_LOG);
            end
            SLSU_OP_XOR:
            begin
                sel_result = r_xor;
                lat_cyc = 4'(SLSU_CYC_LOG);
            end
            SLSU_OP_OR:
            begin
                sel_result = r_or;
                lat_cyc = 4'(SLSU_CYC_LOG);
            end
            SLSU_OP_ADD: sel_result = r_add;
            SLSU_OP_SUB: sel_result = r_sub;
            SLSU_OP_POP:
            begin
                sel_result = r_pop;
                lat_cyc = 4'(SLSU_CYC_CNT);
            end
            SLSU_OP_LZC:
            begin
                sel_result = r_lzc;
                lat_cyc = 4'(SLSU_CYC_CNT);
            end
            SLSU_OP_SHL: sel_result = r_shl;
            SLSU_OP_SHR: sel_result = r_shr;
            SLSU_OP_DSHL: sel_result = r_dshl;
            default: legal_op = 1'b0;
        endcase
    end
    // sequencer: capture at issue, count cycles, present result
    always_comb
    begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        unique case (state_r)
            SLSU_ST_IDLE, SLSU_ST_DONE:
            begin
                state_nxt = SLSU_ST_IDLE;
                if (i_issue && legal_op)
                begin
                    state_nxt = SLSU_ST_BUSY;
                    wait_nxt = lat_cyc - 4'h1;
                end
            end
            SLSU_ST_BUSY:
            begin
                wait_nxt = wait_r - 4'h1;
                if (wait_r == 4'h1)
                    state_nxt = SLSU_ST_DONE;
            end
            default: state_nxt = SLSU_ST_IDLE;
        endcase
    end
    // new issue accepted only when the unit holds no pending result
    assign o_issue_ready = (state_r != SLSU_ST_BUSY);
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_r <= SLSU_ST_IDLE;
            wait_r <= 4'h0;
            hold_r <= SLSU_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            if (i_issue && legal_op && o_issue_ready)
                hold_r <= sel_result;
        end
    end
    // registered result presented for one cycle when destination frees
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            result_r <= SLSU_ZERO;
        else if (state_nxt == SLSU_ST_DONE)
            result_r <= hold_r;
    end
    assign o_busy = (state_r == SLSU_ST_BUSY);
    assign o_result_valid = (state_r == SLSU_ST_DONE);
    // result word comes straight from its flip-flops
    assign o_result = result_r;
endmodule : slsu_unit

/* dv/slsu_unit_props.sv */
// port checks for the scalar logic and shift unit
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module slsu_unit_props
    import slsu_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_issue,
    input wire logic [8:0] i_opcode,
    input wire logic [2:0] i_k_designator,
    input wire logic [5:0] i_parcel_shift_constant,
    input wire logic [63:0] i_first_scalar_operand,
    input wire logic [63:0] i_second_scalar_operand,
    input wire logic [63:0] i_dest_operand,
    input wire logic [31:0] i_shift_count_addr_reg,
    input wire logic o_issue_ready,
    input wire logic o_busy,
    input wire logic o_result_valid,
    input wire logic [63:0] o_result
);
    // accepted issue and opcode classes
    wire legal = i_opcode inside {[SLSU_OP_AND:SLSU_OP_DSHL]};
    wire take = i_issue && o_issue_ready && legal;
    wire logop = i_opcode inside {[SLSU_OP_AND:SLSU_OP_OR]};
    wire cntop = i_opcode inside {SLSU_OP_POP, SLSU_OP_LZC};
    wire ariop = take && !logop && !cntop;
    wire [63:0] a = i_first_scalar_operand;
    wire [63:0] b = i_second_scalar_operand;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    chk_log_done: assert property (
        take && logop |-> ##1 (!o_result_valid)[*3] ##1 o_result_valid)
        else $error("bitwise completion off");
    chk_ari_done: assert property (
        ariop |-> ##1 (!o_result_valid)[*7] ##1 o_result_valid)
        else $error("add or shift completion off");
    chk_cnt_done: assert property (
        take && cntop |-> ##1 (!o_result_valid)[*8] ##1 !o_result_valid
        ##1 !o_result_valid ##1 o_result_valid)
        else $error("count completion off");
    chk_take_busy: assert property (
        take |=> o_busy && !o_issue_ready)
        else $error("unit not busy after issue");
    chk_and_out: assert property (
        take && i_opcode == SLSU_OP_AND
        |-> ##4 o_result == ($past(a, 4) & $past(b, 4)))
        else $error("product result wrong");
    chk_andn_out: assert property (
        take && i_opcode == SLSU_OP_ANDN
        |-> ##4 o_result == ($past(a, 4) & ~$past(b, 4)))
        else $error("and-not result wrong");
    chk_sub_out: assert property (
        take && i_opcode == SLSU_OP_SUB
        |-> ##8 o_result == ($past(a, 8) - $past(b, 8)))
        else $error("difference result wrong");
    chk_parity_out: assert property (
        take && i_opcode == SLSU_OP_POP && i_k_designator[0]
        |-> ##11 o_result == {63'h0, ^$past(a, 11)})
        else $error("parity result wrong");
endmodule : slsu_unit_props
bind slsu_unit slsu_unit_props chk_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_issue(i_issue), .i_opcode(i_opcode), .i_k_designator(i_k_designator),
    .i_parcel_shift_constant(i_parcel_shift_constant),
    .i_first_scalar_operand(i_first_scalar_operand),
    .i_second_scalar_operand(i_second_scalar_operand),
    .i_dest_operand(i_dest_operand),
    .i_shift_count_addr_reg(i_shift_count_addr_reg),
    .o_issue_ready(o_issue_ready), .o_busy(o_busy),
    .o_result_valid(o_result_valid), .o_result(o_result));

/* dv/slsu_issue_model.sv */
// issue control model: requests issue and times completion
// assumes the bench pulses i_go once per instruction
`timescale 1ns/100ps
module slsu_issue_model
(
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic i_ready,
    input wire logic i_valid,
    output logic o_issue,
    output int o_lat
);
    int cnt = 0;
    initial o_issue = 1'b0;
    initial o_lat = 0;
    // hold the request until taken, then count edges to completion
    always @(posedge i_clk_sys)
    begin
        if (i_go)
            o_issue <= 1'b1;
        else if (o_issue && i_ready)
            o_issue <= 1'b0;
        cnt <= (o_issue && i_ready) ? 1 : cnt + 1;
        if (i_valid)
            o_lat <= cnt;
    end
endmodule : slsu_issue_model

/* dv/testbench.sv */
// self-checking bench for the scalar logic and shift unit
// assumes the issue model drives the issue request
`timescale 1ns/100ps
module testbench
    import slsu_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, iss, rdy, busy, vld;
    logic [8:0] opc = 9'h000;
    logic [2:0] kd = 3'h0;
    logic [63:0] fa = 64'h0, sb = 64'h0, dd = 64'h0, res, seed = 64'h9A38;
    logic [31:0] ac = 32'h0;
    int lat, mismatches = 0, comparisons = 0;
    // free-running system clock
    always #5 clk = ~clk;
    slsu_unit dut_u (.i_clk_sys(clk), .i_rst(rst), .i_issue(iss),
        .i_opcode(opc), .i_k_designator(kd), .i_parcel_shift_constant(ac[5:0]),
        .i_first_scalar_operand(fa), .i_second_scalar_operand(sb),
        .i_dest_operand(dd), .i_shift_count_addr_reg(ac),
        .o_issue_ready(rdy), .o_busy(busy), .o_result_valid(vld),
        .o_result(res));
    slsu_issue_model ctl_u (.i_clk_sys(clk), .i_go(go), .i_ready(rdy),
        .i_valid(vld), .o_issue(iss), .o_lat(lat));
    function automatic logic [63:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 7);
        seed = seed ^ (seed << 17);
        return seed;
    endfunction : rnd
    // reference result from the operand values
    function automatic logic [63:0] model(input logic [8:0] op,
        input logic [2:0] k, input logic [63:0] a, b, d, input logic [31:0] c);
        int n;
        logic [127:0] w;
        n = 0;
        w = {d, a} << c;
        for (int i = 0; i < 64; i++) n += int'(a[i]);
        case (op)
            SLSU_OP_AND: return a & b;
            SLSU_OP_ANDN: return a & ~b;
            SLSU_OP_XOR: return a ^ b;
            SLSU_OP_OR: return a | b;
            SLSU_OP_ADD: return a + b;
            SLSU_OP_SUB: return a - b;
            SLSU_OP_POP: return k[0] ? {63'h0, n[0]} : 64'(n);
            SLSU_OP_SHL: return d << c[5:0];
            SLSU_OP_SHR: return d >> c[5:0];
            SLSU_OP_DSHL: return w[127:64];
            default:
            begin
                n = 0;
                while (n < 64 && a[63 - n] == 1'b0) n++;
                return 64'(n);
            end
        endcase
    endfunction : model
    task automatic check(input logic [63:0] got, exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // issue one instruction, wait for completion, compare
    task automatic run(input logic [8:0] op, input logic [2:0] k,
        input logic [63:0] a, b, d, input logic [31:0] c);
        int t;
        int ph;
        t = 0;
        ph = op <= SLSU_OP_OR ? SLSU_PH_LOG_FREE : SLSU_PH_ARI_FREE;
        if (op == SLSU_OP_POP || op == SLSU_OP_LZC) ph = SLSU_PH_CNT_FREE;
        @(posedge clk);
        {opc, kd, fa, sb, dd, ac, go} <= {op, k, a, b, d, c, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        do
        begin
            @(negedge clk);
            t++;
        end
        while (vld !== 1'b1 && t < 40);
        if (t >= 40)
        begin
            mismatches++;
            conclude();
        end
        else
        begin
            check(res, model(op, k, a, b, d, c));
            @(negedge clk);
            check(64'(lat), 64'((ph + 1) / 2));
        end
    endtask : run
    logic [31:0] dcnt [6] = '{32'h0, 32'h1, 32'h40, 32'h7F, 32'h80,
        32'hFFFFFFFF};
    // main sequence: random sweep, boundary cases, refusal
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 4; r++)
            for (int i = 0; i < 11; i++)
                run(SLSU_OP_AND + 9'(i), 3'(r), rnd(), rnd(), rnd(),
                    32'(rnd() & 64'hFF));
        run(SLSU_OP_LZC, 3'h0, 64'h0, 64'h0, 64'h0, 32'h0);
        run(SLSU_OP_LZC, 3'h0, 64'h8000000000000000, 64'h0, 64'h0, 32'h0);
        run(SLSU_OP_POP, 3'h0, 64'hFFFFFFFFFFFFFFFF, 64'h0, 64'h0, 32'h0);
        run(SLSU_OP_POP, 3'h1, 64'hFFFFFFFFFFFFFFFE, 64'h0, 64'h0, 32'h0);
        run(SLSU_OP_SHL, 3'h0, 64'h0, 64'h0, 64'hFFFF, 32'h3F);
        run(SLSU_OP_SHR, 3'h0, 64'h0, 64'h0, 64'h8000000000000001, 32'h3F);
        foreach (dcnt[i])
            run(SLSU_OP_DSHL, 3'h0, rnd(), 64'h0, rnd(), dcnt[i]);
        @(posedge clk);
        {opc, go} <= {9'h000, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(negedge clk);
        check({62'h0, busy, vld}, 64'h0);
        conclude();
    end
endmodule : testbench
